// ===== hdl/tsc_spawner.sv
// thread spawner: child queue, root/child arbitration, descriptor cache, dispatch and dereference
// assumes partner keeps the child queue from overrunning and holds root heads until popped
`timescale 1ns/1ns
`default_nettype none
`include "tsc_params.svh"

module tsc_spawner (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  tsc_if.spawner                         bus,
  input  wire logic                      childrenPresent,
  input  wire logic [`TSC_MAXROOT_W-1:0] maxRoots,
  input  wire logic [`TSC_ADDR_W-1:0]    descBase,
  input  wire logic                      constEn,
  input  wire tsc_pkg::tsc_handle_t      constHandle,
  input  wire logic                      resumeFlag,
  output logic [`TSC_ROOTCNT_W-1:0]      rootCount,
  output logic [`TSC_CHILD_CNT_W-1:0]    childLevel,
  output logic                           busy
);

  tsc_pkg::tsc_child_t         mem [`TSC_CHILD_DEPTH];
  logic [`TSC_CHILD_PTR_W-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [`TSC_CHILD_CNT_W-1:0] cnt_q, cnt_d;
  logic                        push;
  logic                        pop;
  tsc_pkg::tsc_child_t         head;

  tsc_pkg::tsc_state_t         state_q, state_d;
  logic                        jRoot_q, jRoot_d;
  tsc_pkg::tsc_idx_t           jIdx_q, jIdx_d;
  tsc_pkg::tsc_handle_t        jH0_q, jH0_d, jH1_q, jH1_d;
  logic                        jH1v_q, jH1v_d;
  logic                        jConst_q, jConst_d;
  tsc_pkg::tsc_handle_t        jConstH_q, jConstH_d;
  logic                        jResume_q, jResume_d;
  logic [`TSC_DESC_W-1:0]      desc_q, desc_d;
  logic [`TSC_ROOTCNT_W-1:0]   rootCnt_q, rootCnt_d;
  logic                        deref_q, deref_d;
  tsc_pkg::tsc_handle_t        derefH_q, derefH_d;

  logic [`TSC_ADDR_W-1:0]      cTag_q [`TSC_CACHE_WAYS];
  logic [`TSC_DESC_W-1:0]      cData_q [`TSC_CACHE_WAYS];
  logic [`TSC_CACHE_WAYS-1:0]  cValid_q;
  logic [1:0]                  victim_q, victim_d;
  logic                        fill;

  logic [`TSC_ADDR_W-1:0]      lookAddr;
  logic                        hit;
  logic [`TSC_DESC_W-1:0]      hitData;
  logic                        roomRoot;
  logic                        childGo, pairGo, rootGo;
  logic                        rootRun;

  assign head     = mem[rdPtr_q];
  // the partner keeps at most eight in flight, so a push into a full queue cannot occur
  assign push     = bus.spawnValid && cnt_q != `TSC_CHILD_CNT_W'(`TSC_CHILD_DEPTH);
  assign roomRoot = rootCnt_q <= {1'b0, maxRoots};

  // child first; a spawn-root head waits for a synchronized root head
  assign childGo = state_q == tsc_pkg::ST_IDLE && cnt_q != '0 && !head.syncRoot;
  assign pairGo  = state_q == tsc_pkg::ST_IDLE && cnt_q != '0 && head.syncRoot
                   && bus.rootValid && bus.rootSync && roomRoot;
  assign rootGo  = state_q == tsc_pkg::ST_IDLE && !childGo && !pairGo
                   && bus.rootValid && !bus.rootSync && roomRoot;
  assign pop         = childGo || pairGo;
  assign bus.childPop = pop;
  assign bus.rootPop  = pairGo || rootGo;
  assign rootRun      = pairGo || rootGo;

  // equal-sized descriptors: address is base plus scaled index
  assign lookAddr = descBase + (`TSC_ADDR_W'(jIdx_q) << `TSC_DESC_SHIFT);

  always_comb begin
    hit     = 1'b0;
    hitData = '0;
    for (int i = 0; i < `TSC_CACHE_WAYS; i++) begin
      if (cValid_q[i] && cTag_q[i] == lookAddr) begin
        hit     = 1'b1;
        hitData = cData_q[i];
      end
    end
  end

  // one miss outstanding at a time keeps returns in request order
  assign bus.l2ReqValid = state_q == tsc_pkg::ST_FETCH;
  assign bus.l2ReqAddr  = lookAddr;
  assign fill           = state_q == tsc_pkg::ST_FETCH && bus.l2RspValid;

  always_comb begin
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    cnt_d   = cnt_q;
    if (push) begin
      wrPtr_d = wrPtr_q + `TSC_CHILD_PTR_W'(1);
    end
    if (pop) begin
      rdPtr_d = rdPtr_q + `TSC_CHILD_PTR_W'(1);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + `TSC_CHILD_CNT_W'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - `TSC_CHILD_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_q] <= bus.spawnMsg;
    end
  end

  always_comb begin
    state_d   = state_q;
    jRoot_d   = jRoot_q;
    jIdx_d    = jIdx_q;
    jH0_d     = jH0_q;
    jH1_d     = jH1_q;
    jH1v_d    = jH1v_q;
    jConst_d  = jConst_q;
    jConstH_d = jConstH_q;
    jResume_d = jResume_q;
    desc_d    = desc_q;
    rootCnt_d = rootCnt_q;
    deref_d   = 1'b0;
    derefH_d  = derefH_q;
    victim_d  = victim_q;
    unique case (state_q)
      tsc_pkg::ST_IDLE: begin
        jConst_d  = constEn;
        jConstH_d = constHandle;
        if (childGo) begin
          state_d   = tsc_pkg::ST_LOOK;
          jRoot_d   = 1'b0;
          jIdx_d    = head.descIdx;
          jH0_d     = head.bufPtr;
          jH1v_d    = 1'b0;
          jResume_d = 1'b0;
        end else if (rootRun) begin
          state_d   = tsc_pkg::ST_LOOK;
          jRoot_d   = 1'b1;
          jIdx_d    = bus.rootIdx;
          jH0_d     = bus.rootHandle;
          // an empty queue's head is unwritten memory, so keep it off the dispatch bus
          jH1_d     = pairGo ? head.bufPtr : '0;
          jH1v_d    = pairGo;
          jResume_d = resumeFlag;
        end
      end
      tsc_pkg::ST_LOOK: begin
        if (hit) begin
          desc_d  = hitData;
          state_d = tsc_pkg::ST_DISP;
        end else begin
          state_d = tsc_pkg::ST_FETCH;
        end
      end
      tsc_pkg::ST_FETCH: begin
        if (bus.l2RspValid) begin
          desc_d   = bus.l2RspData;
          victim_d = victim_q + 2'h1;
          state_d  = tsc_pkg::ST_DISP;
        end
      end
      tsc_pkg::ST_DISP: begin
        // a child leaves nothing behind and its buffer is never freed here
        if (bus.dispAck) begin
          state_d = tsc_pkg::ST_IDLE;
          if (jRoot_q) begin
            rootCnt_d = rootCnt_q + `TSC_ROOTCNT_W'(1);
            if (!childrenPresent) begin
              deref_d  = 1'b1;
              derefH_d = jH0_q;
            end
          end
        end
      end
    endcase
    if (bus.resDerefValid && childrenPresent) begin
      deref_d  = 1'b1;
      derefH_d = bus.resDerefHandle;
    end
    if (bus.rootRetire && rootCnt_d != '0) begin
      rootCnt_d = rootCnt_d - `TSC_ROOTCNT_W'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrPtr_q   <= '0;
      rdPtr_q   <= '0;
      cnt_q     <= '0;
      state_q   <= tsc_pkg::ST_IDLE;
      jRoot_q   <= 1'b0;
      jIdx_q    <= '0;
      jH0_q     <= '0;
      jH1_q     <= '0;
      jH1v_q    <= 1'b0;
      jConst_q  <= 1'b0;
      jConstH_q <= '0;
      jResume_q <= 1'b0;
      desc_q    <= '0;
      rootCnt_q <= '0;
      deref_q   <= 1'b0;
      derefH_q  <= '0;
      victim_q  <= '0;
    end else begin
      wrPtr_q   <= wrPtr_d;
      rdPtr_q   <= rdPtr_d;
      cnt_q     <= cnt_d;
      state_q   <= state_d;
      jRoot_q   <= jRoot_d;
      jIdx_q    <= jIdx_d;
      jH0_q     <= jH0_d;
      jH1_q     <= jH1_d;
      jH1v_q    <= jH1v_d;
      jConst_q  <= jConst_d;
      jConstH_q <= jConstH_d;
      jResume_q <= jResume_d;
      desc_q    <= desc_d;
      rootCnt_q <= rootCnt_d;
      deref_q   <= deref_d;
      derefH_q  <= derefH_d;
      victim_q  <= victim_d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cValid_q <= '0;
    end else if (fill) begin
      cValid_q[victim_q] <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (fill) begin
      cTag_q[victim_q]  <= lookAddr;
      cData_q[victim_q] <= bus.l2RspData;
    end
  end

  // first-register header only for roots; a child's comes from its parent
  assign bus.dispValid        = state_q == tsc_pkg::ST_DISP;
  assign bus.dispKernel       = desc_q;
  assign bus.dispHandle0      = jH0_q;
  assign bus.dispHandle1      = jH1_q;
  assign bus.dispHandle1Valid = jH1v_q;
  assign bus.dispConstValid   = jConst_q;
  assign bus.dispConstHandle  = jConstH_q;
  assign bus.dispR0Valid      = jRoot_q;
  assign bus.dispR0Resume     = jResume_q;
  assign bus.derefValid       = deref_q;
  assign bus.derefHandle      = derefH_q;
  assign rootCount            = rootCnt_q;
  assign childLevel           = cnt_q;
  assign busy                 = state_q != tsc_pkg::ST_IDLE;

endmodule

`default_nettype wire

// ===== hdl/tsc_params.svh
// constants for the thread spawner and its partner end
// assumes a single 50 MHz clock domain (mclk)
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH

`define TSC_CHILD_DEPTH 8
`define TSC_CHILD_PTR_W 3
`define TSC_CHILD_CNT_W 4
`define TSC_CACHE_WAYS 4
`define TSC_DESC_SHIFT 5
`define TSC_IDX_W 6
`define TSC_HANDLE_W 16
`define TSC_ADDR_W 32
`define TSC_DESC_W 32
`define TSC_MAXROOT_W 7
`define TSC_ROOTCNT_W 8

`endif

// ===== hdl/tsc_pkg.sv
// types shared by the thread spawner, its partner end and the link
// assumes tsc_params.svh is on the include path
`include "tsc_params.svh"

package tsc_pkg;

  typedef logic [`TSC_HANDLE_W-1:0] tsc_handle_t;
  typedef logic [`TSC_IDX_W-1:0]    tsc_idx_t;

  typedef struct packed {
    logic        syncRoot;
    tsc_idx_t    descIdx;
    tsc_handle_t bufPtr;
  } tsc_child_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOOK  = 2'b01,
    ST_FETCH = 2'b10,
    ST_DISP  = 2'b11
  } tsc_state_t;

endpackage

// ===== hdl/tsc_if.sv
// link between the thread spawner and the outside partner (bus arbiter, front end, L2, dispatcher)
// assumes both ends run on the same mclk
`timescale 1ns/1ns
`default_nettype none
`include "tsc_params.svh"

interface tsc_if;
  logic                     spawnValid;
  tsc_pkg::tsc_child_t      spawnMsg;
  logic                     childPop;
  logic                     rootValid;
  logic                     rootSync;
  tsc_pkg::tsc_idx_t        rootIdx;
  tsc_pkg::tsc_handle_t     rootHandle;
  logic                     rootPop;
  logic                     l2ReqValid;
  logic [`TSC_ADDR_W-1:0]   l2ReqAddr;
  logic                     l2RspValid;
  logic [`TSC_DESC_W-1:0]   l2RspData;
  logic                     dispValid;
  logic                     dispAck;
  logic [`TSC_DESC_W-1:0]   dispKernel;
  tsc_pkg::tsc_handle_t     dispHandle0;
  tsc_pkg::tsc_handle_t     dispHandle1;
  logic                     dispHandle1Valid;
  logic                     dispConstValid;
  tsc_pkg::tsc_handle_t     dispConstHandle;
  logic                     dispR0Valid;
  logic                     dispR0Resume;
  logic                     derefValid;
  tsc_pkg::tsc_handle_t     derefHandle;
  logic                     resDerefValid;
  tsc_pkg::tsc_handle_t     resDerefHandle;
  logic                     rootRetire;

  modport spawner (
    input  spawnValid, spawnMsg, rootValid, rootSync, rootIdx, rootHandle,
           l2RspValid, l2RspData, dispAck, resDerefValid, resDerefHandle, rootRetire,
    output childPop, rootPop, l2ReqValid, l2ReqAddr, dispValid, dispKernel, dispHandle0,
           dispHandle1, dispHandle1Valid, dispConstValid, dispConstHandle, dispR0Valid,
           dispR0Resume, derefValid, derefHandle
  );

  modport partner (
    output spawnValid, spawnMsg, rootValid, rootSync, rootIdx, rootHandle,
           l2RspValid, l2RspData, dispAck, resDerefValid, resDerefHandle, rootRetire,
    input  childPop, rootPop, l2ReqValid, l2ReqAddr, dispValid, dispKernel, dispHandle0,
           dispHandle1, dispHandle1Valid, dispConstValid, dispConstHandle, dispR0Valid,
           dispR0Resume, derefValid, derefHandle
  );
endinterface

`default_nettype wire

// ===== hdl/tsc_partner.sv
// partner end of the spawner link: message bus arbiter, front-end head, L2 and dispatcher taps
// assumes user side presents spawn messages, root heads and answers to L2 and dispatch
`timescale 1ns/1ns
`default_nettype none
`include "tsc_params.svh"

module tsc_partner (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  tsc_if.partner                      bus,
  input  wire logic                   usrSpawnValid,
  input  wire logic                   usrSpawnSyncRoot,
  input  wire tsc_pkg::tsc_idx_t      usrSpawnIdx,
  input  wire tsc_pkg::tsc_handle_t   usrSpawnPtr,
  output logic                        usrSpawnReady,
  input  wire logic                   usrRootValid,
  input  wire logic                   usrRootSync,
  input  wire logic                   usrRootResumable,
  input  wire tsc_pkg::tsc_idx_t      usrRootIdx,
  input  wire tsc_pkg::tsc_handle_t   usrRootHandle,
  output logic                        usrRootTaken,
  output logic                        usrRootRefused,
  input  wire logic                   usrFlush,
  output logic                        usrL2ReqValid,
  output logic [`TSC_ADDR_W-1:0]      usrL2ReqAddr,
  input  wire logic                   usrL2RspValid,
  input  wire logic [`TSC_DESC_W-1:0] usrL2RspData,
  input  wire logic                   usrDispAck,
  input  wire logic                   usrResDerefValid,
  input  wire tsc_pkg::tsc_handle_t   usrResDerefHandle,
  input  wire logic                   usrRootRetire
);

  logic [`TSC_CHILD_CNT_W-1:0] credit_q, credit_d;
  logic                        spawnValid_q, spawnValid_d;
  tsc_pkg::tsc_child_t         spawnMsg_q, spawnMsg_d;
  logic                        resumable_q, resumable_d;
  logic                        spawnTake;
  logic                        rootBlock;

  // a parent hands over only a descriptor index, so the child's descriptor always lies
  // in the same array as its parent's and debug fields sit behind bufPtr
  assign usrSpawnReady = credit_q < `TSC_CHILD_CNT_W'(`TSC_CHILD_DEPTH);
  assign spawnTake     = usrSpawnValid && usrSpawnReady;

  // a second resumable root is held back until a pipeline flush command
  assign rootBlock      = usrRootResumable && resumable_q && !usrFlush;
  assign usrRootRefused = usrRootValid && rootBlock;
  assign bus.rootValid  = usrRootValid && !rootBlock;
  assign bus.rootSync   = usrRootSync;
  assign bus.rootIdx    = usrRootIdx;
  assign bus.rootHandle = usrRootHandle;
  assign usrRootTaken   = bus.rootPop;

  assign bus.spawnValid     = spawnValid_q;
  assign bus.spawnMsg       = spawnMsg_q;
  assign usrL2ReqValid      = bus.l2ReqValid;
  assign usrL2ReqAddr       = bus.l2ReqAddr;
  assign bus.l2RspValid     = usrL2RspValid;
  assign bus.l2RspData      = usrL2RspData;
  assign bus.dispAck        = usrDispAck && bus.dispValid;
  assign bus.resDerefValid  = usrResDerefValid;
  assign bus.resDerefHandle = usrResDerefHandle;
  assign bus.rootRetire     = usrRootRetire;

  always_comb begin
    credit_d     = credit_q;
    spawnValid_d = spawnTake;
    spawnMsg_d   = spawnMsg_q;
    resumable_d  = resumable_q;
    // credits come back only on the spawner's removal strobe
    if (spawnTake && !bus.childPop) begin
      credit_d = credit_q + `TSC_CHILD_CNT_W'(1);
    end else if (!spawnTake && bus.childPop && credit_q != '0) begin
      credit_d = credit_q - `TSC_CHILD_CNT_W'(1);
    end
    if (spawnTake) begin
      spawnMsg_d = '{syncRoot: usrSpawnSyncRoot, descIdx: usrSpawnIdx, bufPtr: usrSpawnPtr};
    end
    if (usrFlush) begin
      resumable_d = 1'b0;
    end
    if (bus.rootPop && usrRootResumable) begin
      resumable_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      credit_q     <= '0;
      spawnValid_q <= 1'b0;
      spawnMsg_q   <= '0;
      resumable_q  <= 1'b0;
    end else begin
      credit_q     <= credit_d;
      spawnValid_q <= spawnValid_d;
      spawnMsg_q   <= spawnMsg_d;
      resumable_q  <= resumable_d;
    end
  end

endmodule

`default_nettype wire

// ===== bench/tsc_link_assertions.sv
// checker for the spawner link: sees the link signals only
// assumes one clock mclk and an asynchronous active-high rst
`timescale 1ns/1ns
`default_nettype none
`include "tsc_params.svh"
module tsc_link_assertions (
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic                   spawnValid,
  input wire tsc_pkg::tsc_child_t    spawnMsg,
  input wire logic                   childPop,
  input wire logic                   rootSync,
  input wire logic                   rootPop,
  input wire logic                   l2ReqValid,
  input wire logic [`TSC_ADDR_W-1:0] l2ReqAddr,
  input wire logic                   l2RspValid,
  input wire logic                   dispValid,
  input wire logic                   dispAck,
  input wire logic [`TSC_DESC_W-1:0] dispKernel,
  input wire logic                   dispR0Valid,
  input wire logic                   resDerefValid,
  input wire logic                   derefValid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // shadow of the child queue, so the head's spawn-root bit is known here
  logic [3:0] cnt_q;
  logic [2:0] wr_q;
  logic [2:0] rd_q;
  logic [7:0] sync_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      wr_q <= 3'h0;
      rd_q <= 3'h0;
      sync_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + {3'h0, spawnValid} - {3'h0, childPop};
      wr_q <= wr_q + {2'h0, spawnValid};
      rd_q <= rd_q + {2'h0, childPop};
      if (spawnValid) sync_q[wr_q] <= spawnMsg.syncRoot;
    end
  end
  AST_QUEUE_DEPTH: assert property (cnt_q <= 4'h8)
    else $error("child queue above eight");
  AST_POP_NONEMPTY: assert property (childPop |-> cnt_q != 4'h0)
    else $error("removal from empty child queue");
  AST_CHILD_FIRST: assert property (rootPop && !rootSync |-> cnt_q == 4'h0 || sync_q[rd_q])
    else $error("root served before waiting child");
  AST_SYNC_PAIR: assert property (rootPop && rootSync |-> childPop && sync_q[rd_q])
    else $error("paired root removed alone");
  AST_SPAWN_ROOT_WAITS: assert property (childPop && sync_q[rd_q] |-> rootPop && rootSync)
    else $error("spawn-root removed without paired root");
  AST_ONE_JOB: assert property (dispValid || l2ReqValid |-> !childPop && !rootPop)
    else $error("new job taken while one in flight");
  AST_L2_HOLD: assert property (l2ReqValid && !l2RspValid |=> l2ReqValid && $stable(l2ReqAddr))
    else $error("descriptor request dropped or changed");
  AST_DESC_THEN_DISP: assert property (l2ReqValid && l2RspValid |=> dispValid)
    else $error("no dispatch after descriptor return");
  AST_DISP_HOLD: assert property (dispValid && !dispAck |=> dispValid && $stable(dispKernel))
    else $error("dispatch request not held");
  AST_DEREF_CAUSE: assert property (derefValid |-> $past(resDerefValid) || $past(dispAck) && $past(dispR0Valid))
    else $error("dereference without cause");
  AST_CHILD_NO_DEREF: assert property (dispAck && dispValid && !dispR0Valid && !resDerefValid |=> !derefValid)
    else $error("dereference after child dispatch");
  cover property (rootPop && childPop);
  cover property (cnt_q == 4'h8);
  cover property (l2ReqValid && l2RspValid);
  cover property (derefValid);
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// top bench: spawner and partner joined by the link, user side driven here
// assumes the hdl files are compiled first; one 50 MHz clock
`timescale 1ns/1ns
`default_nettype none
`include "tsc_params.svh"
module tb_top;
  logic                 mclk = 1'b0, rst = 1'b1, usrSpawnValid = 1'b0, usrSpawnSyncRoot = 1'b0, usrSpawnReady;
  logic                 usrRootValid = 1'b0, usrRootSync = 1'b0, usrRootResumable = 1'b0, usrRootTaken;
  logic                 usrRootRefused, usrFlush = 1'b0, usrL2ReqValid, usrL2RspValid = 1'b0, usrDispAck = 1'b0;
  logic                 usrResDerefValid = 1'b0, usrRootRetire = 1'b0, childrenPresent = 1'b0, constEn = 1'b1;
  logic                 resumeFlag = 1'b0, busy, ackEn = 1'b0, r;
  tsc_pkg::tsc_idx_t    usrSpawnIdx = 6'h00, usrRootIdx = 6'h00;
  tsc_pkg::tsc_handle_t usrSpawnPtr = 16'h0000, usrRootHandle = 16'h0000, usrResDerefHandle = 16'h0000;
  tsc_pkg::tsc_handle_t constHandle = 16'h5a0f, derQ[$];
  logic [31:0]          usrL2ReqAddr, usrL2RspData = 32'h0, descBase = 32'h00004000;
  logic [6:0]           maxRoots = 7'h03;
  logic [7:0]           rootCount, lf = 8'h26, ld = 8'h26;
  logic [3:0]           childLevel;
  logic [83:0]          expQ[$], got;
  int                   fails = 0, n_compared = 0, l2n = 0, i, k;
  always #10 mclk = ~mclk;
  tsc_if bus ();
  tsc_spawner u_tsc_spawner (.mclk, .rst, .bus, .childrenPresent, .maxRoots, .descBase, .constEn, .constHandle,
    .resumeFlag, .rootCount, .childLevel, .busy);
  tsc_partner u_tsc_partner (.mclk, .rst, .bus, .usrSpawnValid, .usrSpawnSyncRoot, .usrSpawnIdx, .usrSpawnPtr,
    .usrSpawnReady, .usrRootValid, .usrRootSync, .usrRootResumable, .usrRootIdx, .usrRootHandle, .usrRootTaken,
    .usrRootRefused, .usrFlush, .usrL2ReqValid, .usrL2ReqAddr, .usrL2RspValid, .usrL2RspData, .usrDispAck,
    .usrResDerefValid, .usrResDerefHandle, .usrRootRetire);
  tsc_link_assertions u_tsc_link_assertions (.mclk, .rst, .spawnValid(bus.spawnValid), .spawnMsg(bus.spawnMsg),
    .childPop(bus.childPop), .rootSync(bus.rootSync), .rootPop(bus.rootPop), .l2ReqValid(bus.l2ReqValid),
    .l2ReqAddr(bus.l2ReqAddr), .l2RspValid(bus.l2RspValid), .dispValid(bus.dispValid), .dispAck(bus.dispAck),
    .dispKernel(bus.dispKernel), .dispR0Valid(bus.dispR0Valid), .resDerefValid(bus.resDerefValid),
    .derefValid(bus.derefValid));
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // second-level cache answers with a word tied to the address it was asked for
  function automatic logic [31:0] kern(input logic [5:0] idx);
    return (descBase + {21'h0, idx, 5'h00}) ^ 32'hc3c30000;
  endfunction
  function automatic logic [83:0] rec(input logic r0, rs, h1v, cv, input logic [15:0] h1, h0, ch, input logic [31:0] kd);
    return {r0, r0 & rs, h1v, h1v ? h1 : 16'h0000, h0, cv, cv ? ch : 16'h0000, kd};
  endfunction
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input logic [83:0] a, e, input string m);
    n_compared++;
    if (a !== e) begin
      fails++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic hang(input string m);
    cmp(84'h1, 84'h0, m);
    end_sim;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic push(input logic s, input logic [5:0] idx, input logic [15:0] p);
    usrSpawnValid = 1'b1;
    usrSpawnSyncRoot = s;
    usrSpawnIdx = idx;
    usrSpawnPtr = p;
    if (!s) expQ.push_back(rec(1'b0, 1'b0, 1'b0, constEn, 16'h0, p, constHandle, kern(idx)));
    for (k = 0; k < 300; k++) begin
      @(posedge mclk);
      r = usrSpawnReady;
      #1;
      if (r) break;
    end
    if (!r) hang("spawn message never accepted");
  endtask
  task automatic rootHead(input logic s, rs, input logic [5:0] idx, input logic [15:0] h, p);
    usrRootValid = 1'b1;
    usrRootSync = s;
    usrRootResumable = rs;
    usrRootIdx = idx;
    usrRootHandle = h;
    expQ.push_back(rec(1'b1, resumeFlag, s, constEn, p, h, constHandle, kern(idx)));
    if (!childrenPresent) derQ.push_back(h);
  endtask
  task automatic rootWait;
    for (k = 0; k < 300; k++) begin
      @(posedge mclk);
      r = usrRootTaken;
      #1;
      if (r) break;
    end
    usrRootValid = 1'b0;
    if (!r) hang("root head never taken");
  endtask
  task automatic drain;
    for (k = 0; k < 3000 && (expQ.size() != 0 || busy !== 1'b0); k++) tick(1);
    if (k == 3000) hang("dispatches missing");
    tick(2);
  endtask
  task automatic retire(input int n);
    usrRootRetire = 1'b1;
    tick(n);
    usrRootRetire = 1'b0;
  endtask
  // far side: descriptor returns and dispatch acks after random delays
  always @(posedge mclk) begin
    #1;
    lf = nxt(lf);
    usrL2RspValid = usrL2ReqValid & lf[0];
    usrL2RspData = usrL2ReqAddr ^ 32'hc3c30000;
    usrDispAck = ackEn & bus.dispValid & lf[1];
  end
  always @(posedge mclk) begin
    if (!rst && (bus.dispValid && bus.dispAck) === 1'b1) begin
      got = rec(bus.dispR0Valid, bus.dispR0Resume, bus.dispHandle1Valid, bus.dispConstValid, bus.dispHandle1,
        bus.dispHandle0, bus.dispConstHandle, bus.dispKernel);
      if (expQ.size() == 0) cmp(84'h1, 84'h0, "dispatch with nothing noted");
      else cmp(got, expQ.pop_front(), "dispatch fields");
    end
    if (!rst && bus.derefValid === 1'b1) begin
      if (derQ.size() == 0) cmp(84'h1, 84'h0, "dereference with nothing noted");
      else cmp(84'(bus.derefHandle), 84'(derQ.pop_front()), "dereference handle");
    end
    if (!rst && (usrL2ReqValid && usrL2RspValid) === 1'b1) l2n++;
  end
  initial begin
    tick(4);
    rst = 1'b0;
    tick(1);
    // a stalled root dispatch lets the child queue fill to the brim
    rootHead(1'b0, 1'b0, 6'h00, 16'h0a01, 16'h0);
    rootWait;
    for (i = 0; i < 8; i++) begin
      ld = nxt(ld);
      push(1'b0, 6'(i % 4), {ld, ~ld});
    end
    tick(2);
    cmp(84'({usrSpawnReady, childLevel}), 84'h08, "queue not full at eight");
    ackEn = 1'b1;
    ld = nxt(ld);
    push(1'b0, 6'h03, {ld, ld});
    usrSpawnValid = 1'b0;
    rootHead(1'b0, 1'b0, 6'h01, 16'h0a02, 16'h0);
    rootWait;
    drain;
    cmp(84'(l2n), 84'h4, "descriptor fetch count");
    // root limit and late dereference
    retire(2);
    cmp(84'(rootCount), 84'h0, "root count after retire");
    childrenPresent = 1'b1;
    maxRoots = 7'h00;
    constEn = 1'b0;
    rootHead(1'b0, 1'b0, 6'h04, 16'h0b03, 16'h0);
    rootWait;
    drain;
    rootHead(1'b0, 1'b0, 6'h05, 16'h0b04, 16'h0);
    for (i = 0; i < 20; i++) begin
      tick(1);
      cmp(84'(usrRootTaken), 84'h0, "root taken above limit");
    end
    derQ.push_back(16'h0b03);
    usrResDerefHandle = 16'h0b03;
    usrResDerefValid = 1'b1;
    tick(1);
    usrResDerefValid = 1'b0;
    retire(1);
    rootWait;
    drain;
    // spawn-root waits behind a plain root, then leaves with its partner
    childrenPresent = 1'b0;
    maxRoots = 7'h03;
    retire(2);
    ld = nxt(ld);
    push(1'b1, 6'h02, {ld, 8'h5c});
    usrSpawnValid = 1'b0;
    tick(3);
    cmp(84'(childLevel), 84'h1, "spawn-root not held");
    rootHead(1'b0, 1'b0, 6'h01, 16'h0c05, 16'h0);
    rootWait;
    tick(1);
    rootHead(1'b1, 1'b0, 6'h03, 16'h0c06, {ld, 8'h5c});
    rootWait;
    drain;
    // only one resumable root between flushes
    resumeFlag = 1'b1;
    rootHead(1'b0, 1'b1, 6'h00, 16'h0d07, 16'h0);
    rootWait;
    tick(1);
    rootHead(1'b0, 1'b1, 6'h02, 16'h0d08, 16'h0);
    tick(3);
    cmp(84'({usrRootRefused, usrRootTaken}), 84'h2, "second resumable root not refused");
    usrFlush = 1'b1;
    @(posedge mclk);
    r = usrRootTaken;
    #1;
    usrFlush = 1'b0;
    if (r) usrRootValid = 1'b0;
    else rootWait;
    drain;
    cmp(84'(derQ.size()), 84'h0, "dereferences missing");
    end_sim;
  end
endmodule
`default_nettype wire
